// >>> design/psmw_pkg.sv
// Shared constants and carrier types for the PHY status and MMD window block
package psmw_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 16;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned IRQ_W = 3;

  // Printed offsets are register indices; byte address is four times this
  localparam logic [5:0] IDX_GIG_STATUS = 6'h0a;
  localparam logic [5:0] IDX_C45_CTRL = 6'h0d;
  localparam logic [5:0] IDX_C45_ADDR_DATA = 6'h0e;
  localparam logic [5:0] IDX_GIG_CAP = 6'h0f;
  localparam logic [5:0] IDX_FE_EXT = 6'h10;
  localparam logic [5:0] IDX_GIG_EXT = 6'h11;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h18;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h19;

  localparam logic [1:0] FUNC_ADDR = 2'h0;
  localparam logic [1:0] FUNC_DATA = 2'h1;
  localparam logic [1:0] FUNC_INC_RW = 2'h2;
  localparam logic [1:0] FUNC_INC_WR = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic CAP_FDX = 1'b1;
  localparam logic CAP_HDX = 1'b1;
  localparam logic RESOL_RESET = 1'b1;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;

  // Interrupt status bit positions
  localparam int unsigned IRQ_FAULT = 0;
  localparam int unsigned IRQ_FE = 1;
  localparam int unsigned IRQ_GIG = 2;

  // Self-clearing flag counts, the widths of the fast and gigabit flag vectors
  localparam int unsigned FE_FLAGS = 6;
  localparam int unsigned GIG_FLAGS = 7;

  typedef struct packed {
    logic ms_fault;
    logic ms_master;
    logic lrx_ok;
    logic rrx_ok;
    logic lp_fdx;
    logic lp_hdx;
    logic idle_err;
    logic carr_err;
    logic legacy_lp;
    logic mdix_err;
  } psmw_gig_in_t;

  typedef struct packed {
    logic desc_lock;
    logic lock_err;
    logic disc;
    logic link;
    logic rx_err;
    logic tx_err;
    logic ssd_err;
    logic esd_err;
  } psmw_link_in_t;

  // Register word layouts; field positions follow from the packing
  typedef struct packed {
    logic fault;
    logic resol;
    logic lrx;
    logic rrx;
    logic lp_fdx;
    logic lp_hdx;
    logic [1:0] rsvd;
    logic [CNT_W-1:0] idle_cnt;
  } psmw_gig_word_t;

  typedef struct packed {
    logic [1:0] func;
    logic [8:0] rsvd;
    logic [4:0] dev;
  } psmw_ctrl_word_t;

  typedef struct packed {
    logic [1:0] rsvd_hi;
    logic fdx;
    logic hdx;
    logic [11:0] rsvd_lo;
  } psmw_cap_word_t;

  typedef struct packed {
    logic desc;
    logic lock_err;
    logic disc;
    logic link;
    logic rx_err;
    logic tx_err;
    logic ssd_err;
    logic esd_err;
    logic carr_err;
    logic legacy_lp;
    logic mdix_err;
    logic [4:0] rsvd;
  } psmw_ext_word_t;

  typedef struct packed {
    logic wr;
    logic [4:0] dev;
    logic [REG_W-1:0] addr;
    logic [REG_W-1:0] wdata;
  } psmw_c45_wr_t;

endpackage

// >>> design/psmw_flag_bank.sv
// Bank of self-clearing event flags, cleared by a read strobe
`timescale 1ns/1ps
`default_nettype none

module psmw_flag_bank #(
  parameter int unsigned W = 6
) (
  input wire logic i_sys_clk, // System clock
  input wire logic i_reset, // Synchronous reset, active high
  input wire logic [W-1:0] i_event, // Event pulses, one per flag
  input wire logic i_clear, // Read strobe of the holding register
  output logic [W-1:0] o_flags // Flag levels
);

  logic [W-1:0] flags_ff;

  // An event in the clearing cycle survives the read
  for (genvar g = 0; g < W; g++) begin : g_flag
    always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
        flags_ff[g] <= 1'b0;
      end else if (i_event[g]) begin
        flags_ff[g] <= 1'b1;
      end else if (i_clear) begin
        flags_ff[g] <= 1'b0;
      end
    end
  end

  assign o_flags = flags_ff;

endmodule // psmw_flag_bank

`default_nettype wire

// >>> design/psmw_regs.sv
// PHY gigabit status, extension status and clause 45 window over AXI4-Lite
// Summary of operation
// - Configuration fault latches high until read
// - Resolution bit: 1 master, 0 slave, default 1
// - Local and remote receiver OK bits, reset 0
// - Link partner gigabit duplex capabilities, read-only
// - Function 00 address, 01 data without increment
// - Code 10 increments on read/write; 11 write only
// - Function 00 write loads the held address
// - Data codes forward writes and return reads
// - Own gigabit duplex capabilities fixed at one
// - Fast descrambler lock and link live bits
// - Fast error flags clear after read
// - Delimiter error flags self-clear, both speeds
// - Gigabit descrambler lock and link live bits
// - Gigabit error flags clear after read
// - Carrier extension error flag self-clears
// - Legacy non-compliant partner status bit
// - MDI crossover error status bit
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module psmw_regs (
  input wire logic i_sys_clk, // System clock, 100 MHz
  input wire logic i_reset, // Synchronous reset, active high
  input wire logic [psmw_pkg::ADDR_W-1:0] i_awaddr, // AXI write address
  input wire logic i_awvalid, // AXI write address valid
  output logic o_awready, // AXI write address ready
  input wire logic [psmw_pkg::DATA_W-1:0] i_wdata, // AXI write data
  input wire logic [3:0] i_wstrb, // AXI write byte strobes
  input wire logic i_wvalid, // AXI write data valid
  output logic o_wready, // AXI write data ready
  output logic [1:0] o_bresp, // AXI write response
  output logic o_bvalid, // AXI write response valid
  input wire logic i_bready, // AXI write response ready
  input wire logic [psmw_pkg::ADDR_W-1:0] i_araddr, // AXI read address
  input wire logic i_arvalid, // AXI read address valid
  output logic o_arready, // AXI read address ready
  output logic [psmw_pkg::DATA_W-1:0] o_rdata, // AXI read data
  output logic [1:0] o_rresp, // AXI read response
  output logic o_rvalid, // AXI read data valid
  input wire logic i_rready, // AXI read data ready
  input wire psmw_pkg::psmw_gig_in_t i_gig, // Gigabit PHY status/events
  input wire psmw_pkg::psmw_link_in_t i_fe_link, // 100BASE-TX status/events
  input wire psmw_pkg::psmw_link_in_t i_gig_link, // gigabit_link_status/events
  output psmw_pkg::psmw_c45_wr_t o_c45_wr, // Clause 45 write strobe
  output logic o_c45_rd, // Clause 45 read strobe
  output logic [4:0] o_c45_dev, // Selected clause 45 device
  output logic [psmw_pkg::REG_W-1:0] o_c45_raddr, // Clause 45 read address
  input wire logic [psmw_pkg::REG_W-1:0] i_c45_rdata, // Clause 45 read data
  output logic o_irq // Interrupt, active high level
);

  function automatic logic hit(input logic [psmw_pkg::ADDR_W-1:0] addr,
                               input logic [5:0] idx);
    hit = (addr == {4'h0, idx, 2'h0});
  endfunction

  function automatic logic [psmw_pkg::REG_W-1:0] merge(
      input logic [psmw_pkg::REG_W-1:0] old,
      input logic [psmw_pkg::REG_W-1:0] val,
      input logic [1:0] strb);
    merge = {strb[1] ? val[15:8] : old[15:8], strb[0] ? val[7:0] : old[7:0]};
  endfunction

  // Bus state
  logic aw_held_ff;
  logic w_held_ff;
  logic [psmw_pkg::ADDR_W-1:0] awaddr_ff;
  logic [psmw_pkg::REG_W-1:0] wdata_ff;
  logic [1:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [psmw_pkg::DATA_W-1:0] rdata_ff;

  // Register state
  psmw_pkg::psmw_ctrl_word_t ctrl_ff;
  logic [psmw_pkg::REG_W-1:0] c45_addr_ff;
  psmw_pkg::psmw_c45_wr_t c45_wr_ff;
  logic fault_ff;
  logic resol_ff;
  logic lrx_ff;
  logic rrx_ff;
  logic lp_fdx_ff;
  logic lp_hdx_ff;
  logic [psmw_pkg::CNT_W-1:0] idle_cnt_ff;
  psmw_pkg::psmw_link_in_t fe_live_ff;
  psmw_pkg::psmw_link_in_t gig_live_ff;
  logic legacy_ff;
  logic mdix_ff;
  logic [psmw_pkg::IRQ_W-1:0] irq_stat_ff;
  logic [psmw_pkg::IRQ_W-1:0] irq_mask_ff;

  logic do_write;
  logic rd_fire;
  logic wr_data_mode;
  logic rd_data_mode;
  logic rd_gig;
  logic rd_fe;
  logic rd_gext;
  logic rd_irq;
  logic [psmw_pkg::FE_FLAGS-1:0] fe_evt;
  logic [psmw_pkg::FE_FLAGS-1:0] fe_flags;
  logic [psmw_pkg::GIG_FLAGS-1:0] gig_evt;
  logic [psmw_pkg::GIG_FLAGS-1:0] gig_flags;
  logic [psmw_pkg::IRQ_W-1:0] irq_evt;
  logic [psmw_pkg::REG_W-1:0] nxt_rword;
  psmw_pkg::psmw_gig_word_t gig_word;
  psmw_pkg::psmw_cap_word_t cap_word;
  psmw_pkg::psmw_ext_word_t fe_word;
  psmw_pkg::psmw_ext_word_t gext_word;

  // Write channel: address and data accepted in either order
  assign o_awready = !aw_held_ff && !bvalid_ff;
  assign o_wready = !w_held_ff && !bvalid_ff;
  assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
  assign o_bvalid = bvalid_ff;
  assign o_bresp = bresp_ff;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff <= psmw_pkg::RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff <= i_wdata[psmw_pkg::REG_W-1:0];
        wstrb_ff <= i_wstrb[1:0];
      end
      if (do_write) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= (hit(awaddr_ff, psmw_pkg::IDX_C45_CTRL) ||
                     hit(awaddr_ff, psmw_pkg::IDX_C45_ADDR_DATA) ||
                     hit(awaddr_ff, psmw_pkg::IDX_IRQ_MASK) ||
                     hit(awaddr_ff, psmw_pkg::IDX_GIG_STATUS) ||
                     hit(awaddr_ff, psmw_pkg::IDX_GIG_CAP) ||
                     hit(awaddr_ff, psmw_pkg::IDX_FE_EXT) ||
                     hit(awaddr_ff, psmw_pkg::IDX_GIG_EXT) ||
                     hit(awaddr_ff, psmw_pkg::IDX_IRQ_STATUS)) ?
                    psmw_pkg::RESP_OKAY : psmw_pkg::RESP_SLVERR;
      end else if (bvalid_ff && i_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Read channel: one read at a time, data registered at acceptance
  assign o_arready = !rvalid_ff;
  assign rd_fire = i_arvalid && o_arready;
  assign o_rvalid = rvalid_ff;
  assign o_rdata = rdata_ff;
  assign o_rresp = rresp_ff;

  assign rd_gig = rd_fire && hit(i_araddr, psmw_pkg::IDX_GIG_STATUS);
  assign rd_fe = rd_fire && hit(i_araddr, psmw_pkg::IDX_FE_EXT);
  assign rd_gext = rd_fire && hit(i_araddr, psmw_pkg::IDX_GIG_EXT);
  assign rd_irq = rd_fire && hit(i_araddr, psmw_pkg::IDX_IRQ_STATUS);

  // Window mode decode
  assign wr_data_mode = do_write &&
      hit(awaddr_ff, psmw_pkg::IDX_C45_ADDR_DATA) &&
      (ctrl_ff.func != psmw_pkg::FUNC_ADDR);
  assign rd_data_mode = rd_fire &&
      hit(i_araddr, psmw_pkg::IDX_C45_ADDR_DATA) &&
      (ctrl_ff.func != psmw_pkg::FUNC_ADDR);

  // Read strobe is combinational so the target answers in the same cycle
  assign o_c45_rd = rd_data_mode;
  assign o_c45_raddr = c45_addr_ff;
  assign o_c45_dev = ctrl_ff.dev;
  assign o_c45_wr = c45_wr_ff;

  // Read word assembly
  always_comb begin
    gig_word = '0;
    gig_word.fault = fault_ff || i_gig.ms_fault;
    gig_word.resol = resol_ff;
    gig_word.lrx = lrx_ff;
    gig_word.rrx = rrx_ff;
    gig_word.lp_fdx = lp_fdx_ff;
    gig_word.lp_hdx = lp_hdx_ff;
    gig_word.idle_cnt = idle_cnt_ff;
    cap_word = '0;
    cap_word.fdx = psmw_pkg::CAP_FDX;
    cap_word.hdx = psmw_pkg::CAP_HDX;
    fe_word = '0;
    fe_word.desc = fe_live_ff.desc_lock;
    fe_word.link = fe_live_ff.link;
    {fe_word.lock_err, fe_word.disc, fe_word.rx_err, fe_word.tx_err,
     fe_word.ssd_err, fe_word.esd_err} = fe_flags;
    gext_word = '0;
    gext_word.desc = gig_live_ff.desc_lock;
    gext_word.link = gig_live_ff.link;
    {gext_word.lock_err, gext_word.disc, gext_word.rx_err,
     gext_word.tx_err, gext_word.ssd_err, gext_word.esd_err,
     gext_word.carr_err} = gig_flags;
    gext_word.legacy_lp = legacy_ff;
    gext_word.mdix_err = mdix_ff;
  end

  always_comb begin
    nxt_rword = '0;
    if (hit(i_araddr, psmw_pkg::IDX_GIG_STATUS)) begin
      nxt_rword = gig_word;
    end else if (hit(i_araddr, psmw_pkg::IDX_C45_CTRL)) begin
      nxt_rword = ctrl_ff;
    end else if (hit(i_araddr, psmw_pkg::IDX_C45_ADDR_DATA)) begin
      nxt_rword = (ctrl_ff.func == psmw_pkg::FUNC_ADDR) ?
                  c45_addr_ff : i_c45_rdata;
    end else if (hit(i_araddr, psmw_pkg::IDX_GIG_CAP)) begin
      nxt_rword = cap_word;
    end else if (hit(i_araddr, psmw_pkg::IDX_FE_EXT)) begin
      nxt_rword = fe_word;
    end else if (hit(i_araddr, psmw_pkg::IDX_GIG_EXT)) begin
      nxt_rword = gext_word;
    end else if (hit(i_araddr, psmw_pkg::IDX_IRQ_STATUS)) begin
      nxt_rword = {13'h0, irq_stat_ff};
    end else if (hit(i_araddr, psmw_pkg::IDX_IRQ_MASK)) begin
      nxt_rword = {13'h0, irq_mask_ff};
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= psmw_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= {16'h0, nxt_rword};
      rresp_ff <= (hit(i_araddr, psmw_pkg::IDX_GIG_STATUS) ||
                   hit(i_araddr, psmw_pkg::IDX_C45_CTRL) ||
                   hit(i_araddr, psmw_pkg::IDX_C45_ADDR_DATA) ||
                   hit(i_araddr, psmw_pkg::IDX_GIG_CAP) ||
                   hit(i_araddr, psmw_pkg::IDX_FE_EXT) ||
                   hit(i_araddr, psmw_pkg::IDX_GIG_EXT) ||
                   hit(i_araddr, psmw_pkg::IDX_IRQ_STATUS) ||
                   hit(i_araddr, psmw_pkg::IDX_IRQ_MASK)) ?
                  psmw_pkg::RESP_OKAY : psmw_pkg::RESP_SLVERR;
    end else if (rvalid_ff && i_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Clause 45 window control and held address
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      ctrl_ff <= '0;
    end else if (do_write && hit(awaddr_ff, psmw_pkg::IDX_C45_CTRL)) begin
      ctrl_ff <= merge(ctrl_ff, wdata_ff, wstrb_ff);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      c45_addr_ff <= '0;
    end else if (do_write && hit(awaddr_ff, psmw_pkg::IDX_C45_ADDR_DATA) &&
                 ctrl_ff.func == psmw_pkg::FUNC_ADDR) begin
      c45_addr_ff <= merge(c45_addr_ff, wdata_ff, wstrb_ff);
    end else if (wr_data_mode && (ctrl_ff.func == psmw_pkg::FUNC_INC_RW ||
                 ctrl_ff.func == psmw_pkg::FUNC_INC_WR)) begin
      c45_addr_ff <= c45_addr_ff + 16'h1;
    end else if (rd_data_mode && ctrl_ff.func == psmw_pkg::FUNC_INC_RW) begin
      c45_addr_ff <= c45_addr_ff + 16'h1;
    end
  end

  // Write strobe carries the pre-increment address
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      c45_wr_ff <= '0;
    end else begin
      c45_wr_ff.wr <= wr_data_mode;
      if (wr_data_mode) begin
        c45_wr_ff.dev <= ctrl_ff.dev;
        c45_wr_ff.addr <= c45_addr_ff;
        c45_wr_ff.wdata <= wdata_ff;
      end
    end
  end

  // Gigabit status: latched fault, live bits, idle error count
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      fault_ff <= 1'b0;
    end else if (i_gig.ms_fault) begin
      fault_ff <= 1'b1;
    end else if (rd_gig) begin
      fault_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      resol_ff <= psmw_pkg::RESOL_RESET;
      lrx_ff <= 1'b0;
      rrx_ff <= 1'b0;
      lp_fdx_ff <= 1'b0;
      lp_hdx_ff <= 1'b0;
      fe_live_ff <= '0;
      gig_live_ff <= '0;
      legacy_ff <= 1'b0;
      mdix_ff <= 1'b0;
    end else begin
      resol_ff <= i_gig.ms_master;
      lrx_ff <= i_gig.lrx_ok;
      rrx_ff <= i_gig.rrx_ok;
      lp_fdx_ff <= i_gig.lp_fdx;
      lp_hdx_ff <= i_gig.lp_hdx;
      fe_live_ff <= i_fe_link;
      gig_live_ff <= i_gig_link;
      legacy_ff <= i_gig.legacy_lp;
      mdix_ff <= i_gig.mdix_err;
    end
  end

  // Saturating count; an error in the reading cycle starts the next count
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      idle_cnt_ff <= '0;
    end else if (rd_gig) begin
      idle_cnt_ff <= {7'h0, i_gig.idle_err};
    end else if (i_gig.idle_err && idle_cnt_ff != psmw_pkg::CNT_MAX) begin
      idle_cnt_ff <= idle_cnt_ff + 8'h1;
    end
  end

  // Self-clearing extension flags
  assign fe_evt = {i_fe_link.lock_err, i_fe_link.disc, i_fe_link.rx_err,
                   i_fe_link.tx_err, i_fe_link.ssd_err, i_fe_link.esd_err};
  assign gig_evt = {i_gig_link.lock_err, i_gig_link.disc, i_gig_link.rx_err,
                    i_gig_link.tx_err, i_gig_link.ssd_err,
                    i_gig_link.esd_err, i_gig.carr_err};

  psmw_flag_bank #(
    .W(psmw_pkg::FE_FLAGS)
  ) u_fe_flags (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_event(fe_evt),
    .i_clear(rd_fe),
    .o_flags(fe_flags)
  );

  psmw_flag_bank #(
    .W(psmw_pkg::GIG_FLAGS)
  ) u_gig_flags (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_event(gig_evt),
    .i_clear(rd_gext),
    .o_flags(gig_flags)
  );

  // Interrupt status, cleared by its own read; set wins over clear
  assign irq_evt = {|gig_evt, |fe_evt, i_gig.ms_fault};

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= irq_evt | (rd_irq ? '0 : irq_stat_ff);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      irq_mask_ff <= '0;
    end else if (do_write && hit(awaddr_ff, psmw_pkg::IDX_IRQ_MASK) &&
                 wstrb_ff[0]) begin
      irq_mask_ff <= wdata_ff[psmw_pkg::IRQ_W-1:0];
    end
  end

  assign o_irq = |(irq_stat_ff & irq_mask_ff);

  // Checks
  a_fault_latch: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    fault_ff && !rd_gig |=> fault_ff)
    else $error("fault bit dropped before it was read");
  a_fault_sets: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_gig.ms_fault |=> gig_word.fault)
    else $error("fault event not latched");
  a_idle_clear: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    rd_gig && !i_gig.idle_err |=> idle_cnt_ff == 8'h0)
    else $error("idle count not cleared by read");
  a_addr_load: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    do_write && hit(awaddr_ff, psmw_pkg::IDX_C45_ADDR_DATA) &&
    ctrl_ff.func == psmw_pkg::FUNC_ADDR && wstrb_ff == 2'h3
    |=> c45_addr_ff == $past(wdata_ff))
    else $error("window address not loaded");
  a_inc_write: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    wr_data_mode && ctrl_ff.func[1]
    |=> c45_addr_ff == $past(c45_addr_ff) + 16'h1)
    else $error("address not advanced after write");
  a_noinc_read: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    rd_data_mode && ctrl_ff.func != psmw_pkg::FUNC_INC_RW && !do_write
    |=> $stable(c45_addr_ff))
    else $error("address moved on a read without increment");
  a_fwd_write: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    wr_data_mode |=> o_c45_wr.wr && o_c45_wr.addr == $past(c45_addr_ff)
    ##1 !o_c45_wr.wr || $past(wr_data_mode))
    else $error("window write not forwarded once");
  a_fe_clear: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    rd_fe && fe_evt == '0 |=> fe_flags == '0)
    else $error("fast flags not cleared by read");
  a_gig_clear: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    rd_gext && gig_evt == '0 |=> gig_flags == '0)
    else $error("gigabit flags not cleared by read");
  a_bresp_hold: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response withdrawn early");

  c_inc_rw: cover property (@(posedge i_sys_clk) disable iff (i_reset)
    rd_data_mode && ctrl_ff.func == psmw_pkg::FUNC_INC_RW);
  c_fault_read: cover property (@(posedge i_sys_clk) disable iff (i_reset)
    fault_ff ##1 rd_gig);
  c_irq: cover property (@(posedge i_sys_clk) disable iff (i_reset)
    $rose(o_irq));

endmodule // psmw_regs

`default_nettype wire

// >>> test/psmw_c45_model.sv
// Clause 45 register store that answers the window's held read address and write strobes
`timescale 1ns/1ps
`default_nettype none

module psmw_c45_model (
  input wire logic i_sys_clk, // System clock
  input wire psmw_pkg::psmw_c45_wr_t i_wr, // Write strobe bundle
  input wire logic [15:0] i_raddr, // Held read address
  output logic [15:0] o_rdata // Read data, combinational
);
  logic [15:0] mem [0:15];

  // Distinct preset contents so a stale address shows up in the data
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 16'h5a00 + 16'(i);
  end

  always @(posedge i_sys_clk) begin
    if (i_wr.wr) mem[i_wr.addr[3:0]] <= i_wr.wdata;
  end

  assign o_rdata = mem[i_raddr[3:0]];
endmodule // psmw_c45_model

`default_nettype wire

// >>> test/tb_top.sv
// Register-level testbench for the PHY status and clause 45 window block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clk = 1'b0, rst = 1'b1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic aw_rdy, w_rdy, bvalid, ar_rdy, rvalid, irq, c45_rd;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [9:0] ig = 10'h100;
  logic [7:0] fe = 8'h00, gl = 8'h00;
  logic [4:0] dev;
  logic [15:0] raddr, c45_rdata;
  psmw_pkg::psmw_c45_wr_t c45_wr;
  int n_errors = 0, cmp_count = 0;
  int n_c45_rd = 0;

  always #5 clk = ~clk;

  // Window read strobes seen by the far side, one per data-mode read
  always @(posedge clk) begin
    if (c45_rd) n_c45_rd++;
  end

  psmw_regs uut (.i_sys_clk(clk), .i_reset(rst), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(aw_rdy), .i_wdata(wdata),
    .i_wstrb(4'h3), .i_wvalid(wvalid), .o_wready(w_rdy), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(ar_rdy), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_gig(ig),
    .i_fe_link(fe), .i_gig_link(gl), .o_c45_wr(c45_wr), .o_c45_rd(c45_rd),
    .o_c45_dev(dev), .o_c45_raddr(raddr), .i_c45_rdata(c45_rdata),
    .o_irq(irq));

  psmw_c45_model far (.i_sys_clk(clk), .i_wr(c45_wr), .i_raddr(raddr),
    .o_rdata(c45_rdata));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d,
                    input logic [1:0] er = 2'h0);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && aw_rdy) awvalid <= 1'b0;
      if (wvalid && w_rdy) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] ed,
                    input logic [1:0] er = 2'h0);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && ar_rdy) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(rdata, {16'h0000, ed});
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    finish_test();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(12'h028, 16'h4000);
    rd(12'h03c, 16'h3000);
    wr(12'h03c, 16'hffff);
    rd(12'h03c, 16'h3000);
    rd(12'h040, 16'h0000);
    rd(12'h044, 16'h0000);
    wr(12'h008, 16'h1234, 2'h2);
    rd(12'h008, 16'h0000, 2'h2);
    // Slave, receivers up, partner capable; every event held high for two cycles
    ig <= 10'h2ff;
    fe <= 8'hff;
    gl <= 8'hff;
    repeat (2) @(posedge clk);
    ig <= 10'h0f3;
    fe <= 8'h90;
    gl <= 8'h90;
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(12'h064, 16'h0007);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    rd(12'h060, 16'h0007);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rd(12'h028, 16'hbc02);
    rd(12'h028, 16'h3c00);
    rd(12'h040, 16'hff00);
    rd(12'h040, 16'h9000);
    rd(12'h044, 16'hffe0);
    rd(12'h044, 16'h9060);
    wr(12'h034, 16'h0003);
    wr(12'h038, 16'h0004);
    rd(12'h038, 16'h0004);
    wr(12'h034, 16'h8003);
    wr(12'h038, 16'habcd);
    rd(12'h038, 16'h5a05);
    wr(12'h034, 16'h4003);
    rd(12'h038, 16'h5a06);
    rd(12'h038, 16'h5a06);
    wr(12'h034, 16'hc003);
    rd(12'h038, 16'h5a06);
    wr(12'h038, 16'h1234);
    wr(12'h034, 16'h0003);
    rd(12'h038, 16'h0007);
    wr(12'h038, 16'h0004);
    wr(12'h034, 16'h4003);
    rd(12'h038, 16'habcd);
    rd(12'h034, 16'h4003);
    chk({27'h0, dev}, 32'h3);
    chk(n_c45_rd, 32'h5);
    finish_test();
  end
endmodule // tb_top

`default_nettype wire
